// File: shared/burst_seq_defs.svh
// constant definitions for the light-load burst sequencer
// assumes a 10 MHz core clock; included by bare name
`ifndef BURST_SEQ_DEFS_SVH
`define BURST_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------------
`define CLK_HZ 10000000
`define CLK_PERIOD_NS 100
`define WAKE_DELAY_NS 2200
`define WAKE_DELAY_CYC ((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// burst frequency limits, as periods in clock cycles
// ----------------------------------------------------------------------
`define BURST_LOW_LIMIT_HZ 25000
`define LOW_POWER_RATE_HZ 25000
`define STANDBY_UPPER_HZ 8500
`define STANDBY_LOWER_HZ 1700
`define BURST_LOW_PERIOD_CYC (`CLK_HZ / `BURST_LOW_LIMIT_HZ)
`define LOW_POWER_PERIOD_CYC (`CLK_HZ / `LOW_POWER_RATE_HZ)
`define STANDBY_UPPER_PERIOD_CYC (`CLK_HZ / `STANDBY_UPPER_HZ)
`define STANDBY_LOWER_PERIOD_CYC (`CLK_HZ / `STANDBY_LOWER_HZ)

// ----------------------------------------------------------------------
// pulse counts and qualification
// ----------------------------------------------------------------------
`define PULSES_BASE 4'h2
`define QUALIFY_PERIODS 2'h2
`define BLANKING_CYC 3
`define MIN_ON_CYC 1

// ----------------------------------------------------------------------
// synchronised input bit positions
// ----------------------------------------------------------------------
`define SY_ZC 0
`define SY_DEMAND 1
`define SY_TRIP 2
`define SY_FLOOR 3
`define SY_PROG_HI 4
`define SY_SET_REF 5
`define SY_W 6

`endif

// File: shared/burst_seq_pkg.sv
// types shared by the burst sequencer and its bench
// no assumptions beyond a SystemVerilog tool
package burst_seq_pkg;

    typedef enum logic [1:0] {
        MODE_ADAPTIVE,
        MODE_LOW_POWER,
        MODE_STANDBY1,
        MODE_STANDBY2
    } mode_e;

    typedef enum logic [2:0] {
        PK_IDLE,
        PK_WAKE,
        PK_VALLEY,
        PK_ON,
        PK_OFF
    } packet_e;

endpackage

// File: verilog/light_load_burst_mode_sequencer.sv
// light-load burst sequencer: low power, first and second standby modes
// assumes one 10 MHz clock; analog comparators arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "burst_seq_defs.svh"

module light_load_burst_mode_sequencer #(
    parameter int PERIOD_W = 14,
    parameter int CODE_W = 8,
    parameter int ON_W = 8,
    parameter logic [CODE_W-1:0] THRESH_FLOOR_CODE = 8'h10,
    parameter logic [CODE_W-1:0] PROG_MIN_CODE = 8'h45,
    parameter logic [CODE_W-1:0] PROG_MAX_CODE = 8'h66,
    parameter int STANDBY_LOWER_PERIOD = `STANDBY_LOWER_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_aux_zero_cross,
    input wire logic i_demand,
    input wire logic i_peak_trip,
    input wire logic i_peak_at_floor,
    input wire logic i_program_above,
    input wire logic i_set_tied_ref,
    input wire logic i_adaptive_start,
    input wire logic [3:0] i_adaptive_pulses,
    input wire logic [CODE_W-1:0] i_loop_code,
    input wire logic [CODE_W-1:0] i_program_code,
    input wire logic [ON_W-1:0] i_on_time_code,
    output logic o_low_side_gate,
    output logic o_high_side_gate,
    output logic o_driver_wake,
    output burst_seq_pkg::mode_e o_mode,
    output logic [3:0] o_pulses_per_packet,
    output logic [CODE_W-1:0] o_peak_current_threshold,
    output logic o_voltage_mode
);
    import burst_seq_pkg::*;

    // ------------------------------------------------------------------
    // constants at working widths
    // ------------------------------------------------------------------
    localparam logic [PERIOD_W-1:0] LOW_LIMIT_P = PERIOD_W'(`BURST_LOW_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] LOW_RATE_P = PERIOD_W'(`LOW_POWER_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] UPPER_P = PERIOD_W'(`STANDBY_UPPER_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] LOWER_P = PERIOD_W'(STANDBY_LOWER_PERIOD);
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = {PERIOD_W{1'b1}};
    localparam logic [4:0] WAKE_CYC = 5'(`WAKE_DELAY_CYC);
    localparam logic [ON_W-1:0] BLANK_CYC = ON_W'(`BLANKING_CYC);
    localparam logic [ON_W-1:0] MIN_ON = ON_W'(`MIN_ON_CYC);
    localparam logic [ON_W-1:0] ON_MAX = {ON_W{1'b1}};

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] c);
        return (c < PROG_MIN_CODE) ? PROG_MIN_CODE : ((c > PROG_MAX_CODE) ? PROG_MAX_CODE : c);
    endfunction

    function automatic logic [3:0] packet_pulses(input mode_e m);
        return (m == MODE_STANDBY2) ? 4'(`PULSES_BASE << 1) : `PULSES_BASE;
    endfunction

    // ------------------------------------------------------------------
    // input synchronisers: three stages, a change counts when 2 and 3 agree
    // ------------------------------------------------------------------
    logic [`SY_W-1:0] sy1_r;
    logic [`SY_W-1:0] sy2_r;
    logic [`SY_W-1:0] sy3_r;
    logic [`SY_W-1:0] in_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
            in_r <= '0;
        end else begin
            sy1_r <= {i_set_tied_ref, i_program_above, i_peak_at_floor,
                      i_peak_trip, i_demand, i_aux_zero_cross};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            for (int k = 0; k < `SY_W; k++) begin
                if (sy2_r[k] == sy3_r[k]) begin
                    in_r[k] <= sy3_r[k];
                end
            end
        end
    end

    logic zc_edge;
    assign zc_edge = (sy2_r[`SY_ZC] == sy3_r[`SY_ZC]) && sy3_r[`SY_ZC] && !in_r[`SY_ZC];

    // ------------------------------------------------------------------
    // packet start decision
    // ------------------------------------------------------------------
    mode_e mode_r;
    packet_e pk_r;
    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] rate_r;
    logic start_pk;

    // standby packets only begin when the loop asks for energy, so the
    // off-time stretches with load; low power runs on its own fixed timer
    always_comb begin
        start_pk = 1'b0;
        if (pk_r == PK_IDLE) begin
            unique case (mode_r)
                MODE_ADAPTIVE: start_pk = 1'b0;
                MODE_LOW_POWER: start_pk = (rate_r >= LOW_RATE_P - 1'b1);
                MODE_STANDBY1,
                MODE_STANDBY2: start_pk = in_r[`SY_DEMAND];
            endcase
        end
    end

    logic burst_start;
    assign burst_start = (mode_r == MODE_ADAPTIVE) ? i_adaptive_start : start_pk;

    // ------------------------------------------------------------------
    // burst period measurement
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            period_r <= '0;
        end else if (burst_start) begin
            period_r <= '0;
        end else if (period_r != PERIOD_MAX) begin
            period_r <= period_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rate_r <= '0;
        end else if (mode_r != MODE_LOW_POWER || start_pk) begin
            rate_r <= '0;
        end else if (rate_r != PERIOD_MAX) begin
            rate_r <= rate_r + 1'b1;
        end
    end

    // the measured period is one more than the count reached when the next start lands
    logic [PERIOD_W:0] meas_full;
    logic [PERIOD_W-1:0] meas;
    assign meas_full = {1'b0, period_r} + 1'b1;
    assign meas = (period_r == PERIOD_MAX) ? PERIOD_MAX : meas_full[PERIOD_W-1:0];

    // ------------------------------------------------------------------
    // mode transitions
    // ------------------------------------------------------------------
    logic [1:0] slow_cnt_r;
    logic slow_period;
    assign slow_period = meas > LOW_LIMIT_P;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slow_cnt_r <= '0;
        end else if (mode_r != MODE_ADAPTIVE) begin
            slow_cnt_r <= '0;
        end else if (i_adaptive_start) begin
            if (i_adaptive_pulses == `PULSES_BASE && slow_period) begin
                slow_cnt_r <= (slow_cnt_r == `QUALIFY_PERIODS) ? slow_cnt_r
                                                               : slow_cnt_r + 1'b1;
            end else begin
                slow_cnt_r <= '0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_r <= MODE_ADAPTIVE;
        end else begin
            unique case (mode_r)
                MODE_ADAPTIVE: if (slow_cnt_r == `QUALIFY_PERIODS) begin
                    mode_r <= MODE_LOW_POWER;
                end
                MODE_LOW_POWER: if (in_r[`SY_FLOOR]) begin
                    mode_r <= MODE_STANDBY1;
                end
                MODE_STANDBY1: if (burst_start && meas > UPPER_P) begin
                    mode_r <= MODE_STANDBY2;
                end
                MODE_STANDBY2: if (burst_start && (in_r[`SY_PROG_HI]
                        ? (meas < LOWER_P)
                        : (meas < UPPER_P))) begin
                    mode_r <= MODE_STANDBY1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // packet sequencer: wake, valley-started pulses, wait for last valley
    // ------------------------------------------------------------------
    logic [4:0] wake_cnt_r;
    logic [ON_W-1:0] on_cnt_r;
    logic [3:0] pulse_cnt_r;
    logic [3:0] target_r;
    logic [ON_W-1:0] on_goal;
    logic pulse_end;

    // voltage mode times the pulse directly, so it may end before blanking
    // would have let the current comparator act
    assign on_goal = (i_on_time_code < MIN_ON) ? MIN_ON : i_on_time_code;
    assign pulse_end = o_voltage_mode ? (on_cnt_r >= on_goal)
                                      : (on_cnt_r >= BLANK_CYC && in_r[`SY_TRIP]);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pk_r <= PK_IDLE;
            wake_cnt_r <= '0;
            on_cnt_r <= '0;
            pulse_cnt_r <= '0;
            target_r <= `PULSES_BASE;
        end else begin
            unique case (pk_r)
                PK_IDLE: begin
                    if (start_pk) begin
                        pk_r <= PK_WAKE;
                        wake_cnt_r <= '0;
                        pulse_cnt_r <= '0;
                        target_r <= packet_pulses(mode_r);
                    end
                end
                PK_WAKE: begin
                    wake_cnt_r <= wake_cnt_r + 1'b1;
                    if (wake_cnt_r >= WAKE_CYC - 1'b1) begin
                        pk_r <= PK_VALLEY;
                    end
                end
                PK_VALLEY: begin
                    if (zc_edge) begin
                        pk_r <= PK_ON;
                        on_cnt_r <= '0;
                        pulse_cnt_r <= pulse_cnt_r + 1'b1;
                    end
                end
                PK_ON: begin
                    if (on_cnt_r != ON_MAX) begin
                        on_cnt_r <= on_cnt_r + 1'b1;
                    end
                    if (pulse_end) begin
                        pk_r <= PK_OFF;
                    end
                end
                PK_OFF: begin
                    if (zc_edge) begin
                        if (pulse_cnt_r >= target_r) begin
                            pk_r <= PK_IDLE;
                        end else begin
                            pk_r <= PK_ON;
                            on_cnt_r <= '0;
                            pulse_cnt_r <= pulse_cnt_r + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registered outputs: gate and wake set from the next-state view, mode outputs from the current state, high side held low
    // ------------------------------------------------------------------
    logic gate_nxt;
    logic wake_nxt;
    always_comb begin
        gate_nxt = 1'b0;
        wake_nxt = (pk_r != PK_IDLE) || start_pk;
        unique case (pk_r)
            PK_IDLE,
            PK_WAKE: gate_nxt = 1'b0;
            PK_VALLEY: gate_nxt = zc_edge;
            PK_ON: gate_nxt = !pulse_end;
            PK_OFF: begin
                gate_nxt = zc_edge && (pulse_cnt_r < target_r);
                wake_nxt = !(zc_edge && pulse_cnt_r >= target_r);
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_low_side_gate <= 1'b0;
            o_driver_wake <= 1'b0;
            o_high_side_gate <= 1'b0;
        end else begin
            o_low_side_gate <= gate_nxt;
            o_driver_wake <= wake_nxt;
            o_high_side_gate <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mode <= MODE_ADAPTIVE;
            o_pulses_per_packet <= `PULSES_BASE;
            o_peak_current_threshold <= '0;
            o_voltage_mode <= 1'b0;
        end else begin
            o_mode <= mode_r;
            o_pulses_per_packet <= packet_pulses(mode_r);
            o_voltage_mode <= (mode_r == MODE_LOW_POWER) && in_r[`SY_SET_REF];
            unique case (mode_r)
                MODE_ADAPTIVE,
                MODE_LOW_POWER: o_peak_current_threshold <= i_loop_code;
                MODE_STANDBY1: o_peak_current_threshold <= THRESH_FLOOR_CODE;
                MODE_STANDBY2: o_peak_current_threshold <= in_r[`SY_PROG_HI]
                    ? clamp_code(i_program_code)
                    : PROG_MIN_CODE;
            endcase
        end
    end

endmodule // light_load_burst_mode_sequencer

`default_nettype wire

// File: verification/burst_seq_props.sv
// concurrent checks on the burst sequencer top-level ports
// assumes binding into the sequencer top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module burst_seq_props #(
    parameter int CODE_W = 8,
    parameter logic [CODE_W-1:0] THRESH_FLOOR_CODE = 8'h10,
    parameter logic [CODE_W-1:0] PROG_MIN_CODE = 8'h45,
    parameter logic [CODE_W-1:0] PROG_MAX_CODE = 8'h66
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_program_above,
    input wire logic i_set_tied_ref,
    input wire logic o_low_side_gate,
    input wire logic o_high_side_gate,
    input wire logic o_driver_wake,
    input wire burst_seq_pkg::mode_e o_mode,
    input wire logic [3:0] o_pulses_per_packet,
    input wire logic [CODE_W-1:0] o_peak_current_threshold,
    input wire logic o_voltage_mode
);
    import burst_seq_pkg::*;
    logic wake_q_r;
    logic gate_q_r;
    logic lp_prev_r;
    logic [3:0] pcnt_r;
    logic [3:0] ppp_r;
    logic [15:0] per_r;
    wire logic rise = o_driver_wake & ~wake_q_r;
    // ----------------------------------------------------------------
    // pulse and period counters
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_q_r <= 1'b0;
            gate_q_r <= 1'b0;
            lp_prev_r <= 1'b0;
            pcnt_r <= 4'h0;
            ppp_r <= 4'h0;
            per_r <= 16'h0;
        end else begin
            wake_q_r <= o_driver_wake;
            gate_q_r <= o_low_side_gate;
            pcnt_r <= !o_driver_wake ? 4'h0 : pcnt_r + {3'h0, o_low_side_gate & ~gate_q_r};
            // saturates so a long standby gap cannot wrap into a false match
            per_r <= rise ? 16'h1 : per_r + {15'h0, ~&per_r};
            if (rise) begin
                lp_prev_r <= (o_mode == MODE_LOW_POWER);
                ppp_r <= o_pulses_per_packet;
            end
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_hs_off;
        o_high_side_gate == 1'b0;
    endproperty
    a_hs_off: assert property (p_hs_off) else $error("high side on");
    property p_wake_lead;
        $rose(o_low_side_gate) && o_mode != MODE_ADAPTIVE |-> $past(o_driver_wake, 22);
    endproperty
    a_wake_lead: assert property (p_wake_lead) else $error("gate too early");
    property p_pkt_count;
        $fell(o_driver_wake) && o_mode != MODE_ADAPTIVE |-> pcnt_r == ppp_r;
    endproperty
    a_pkt_count: assert property (p_pkt_count) else $error("pulse count");
    property p_pkt_size;
        $rose(o_driver_wake) && o_mode != MODE_ADAPTIVE |->
            ##1 o_pulses_per_packet == ((o_mode == MODE_STANDBY2) ? 4'h4 : 4'h2);
    endproperty
    a_pkt_size: assert property (p_pkt_size) else $error("packet size");
    property p_lp_period;
        rise && lp_prev_r && o_mode == MODE_LOW_POWER |-> per_r == 16'h190;
    endproperty
    a_lp_period: assert property (p_lp_period) else $error("lp period");
    property p_order;
        $changed(o_mode) |-> o_mode == $past(o_mode) + 2'h1
            || (o_mode == MODE_STANDBY1 && $past(o_mode) == MODE_STANDBY2);
    endproperty
    a_order: assert property (p_order) else $error("mode order");
    property p_sb1_floor;
        (o_mode == MODE_STANDBY1) [*3] |-> o_peak_current_threshold == THRESH_FLOOR_CODE;
    endproperty
    a_sb1_floor: assert property (p_sb1_floor) else $error("sb1 threshold");
    property p_sb2_range;
        (o_mode == MODE_STANDBY2) [*3] |-> o_peak_current_threshold >= PROG_MIN_CODE
            && o_peak_current_threshold <= PROG_MAX_CODE;
    endproperty
    a_sb2_range: assert property (p_sb2_range) else $error("sb2 range");
    property p_sb2_low;
        (o_mode == MODE_STANDBY2 && !i_program_above) [*6] |->
            o_peak_current_threshold == PROG_MIN_CODE;
    endproperty
    a_sb2_low: assert property (p_sb2_low) else $error("sb2 low");
    property p_vmode;
        (o_mode == MODE_LOW_POWER && i_set_tied_ref) [*6] |-> o_voltage_mode;
    endproperty
    a_vmode: assert property (p_vmode) else $error("voltage mode");
    property p_rst;
        disable iff (1'b0) (!i_resetn) [*2] |-> !o_driver_wake && !o_low_side_gate
            && o_mode == MODE_ADAPTIVE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    c_lp: cover property (o_mode == MODE_LOW_POWER && rise);
    c_sb2: cover property (o_mode == MODE_STANDBY2 && rise);
    c_vm: cover property (o_voltage_mode && $rose(o_low_side_gate));
endmodule // burst_seq_props
bind light_load_burst_mode_sequencer burst_seq_props #(
    .CODE_W(CODE_W),
    .THRESH_FLOOR_CODE(THRESH_FLOOR_CODE),
    .PROG_MIN_CODE(PROG_MIN_CODE),
    .PROG_MAX_CODE(PROG_MAX_CODE)
) u_props (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_program_above(i_program_above),
    .i_set_tied_ref(i_set_tied_ref),
    .o_low_side_gate(o_low_side_gate),
    .o_high_side_gate(o_high_side_gate),
    .o_driver_wake(o_driver_wake),
    .o_mode(o_mode),
    .o_pulses_per_packet(o_pulses_per_packet),
    .o_peak_current_threshold(o_peak_current_threshold),
    .o_voltage_mode(o_voltage_mode)
);
`default_nettype wire

// File: verification/burst_power_stage_model.sv
// gate driver, switch and aux winding as the sequencer sees them
// assumes the bench clock; slow stretches ringing and current ramp
`timescale 1ns/1ps
`default_nettype none
module burst_power_stage_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_gate,
    input wire logic i_wake,
    input wire logic i_slow,
    output logic o_zero_cross,
    output logic o_peak_trip
);
    logic [5:0] cnt_r;
    logic gate_q_r;
    logic [5:0] ring;
    logic [5:0] ramp;
    assign ring = i_slow ? 6'h14 : 6'h06;
    assign ramp = i_slow ? 6'h0C : 6'h04;
    // a sleeping driver leaves the comparators at rest, low
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 6'h0;
            gate_q_r <= 1'b0;
            o_zero_cross <= 1'b0;
            o_peak_trip <= 1'b0;
        end else begin
            gate_q_r <= i_gate;
            cnt_r <= (!i_wake || i_gate != gate_q_r || (!i_gate && cnt_r == ring + 6'h4))
                ? 6'h0 : cnt_r + 6'h1;
            o_zero_cross <= i_wake && !i_gate && cnt_r >= ring;
            o_peak_trip <= i_wake && i_gate && cnt_r >= ramp;
        end
    end
endmodule // burst_power_stage_model
`default_nettype wire

// File: verification/tb_light_load_burst_mode_sequencer.sv
// self-checking bench for the light-load burst sequencer
// assumes the power stage model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "burst_seq_defs.svh"
module tb_light_load_burst_mode_sequencer;
    import burst_seq_pkg::*;
    localparam int LOWER = 3000;
    localparam logic [7:0] PMIN = 8'h45;
    localparam logic [7:0] PMAX = 8'h66;
    logic i_clk, i_resetn, zc, dem, trip, flr, prg, tie, ast, slow, gate, hs, wake, vm;
    logic [3:0] apul, ppp;
    logic [7:0] loop_c, prog_c, on_c, thr;
    mode_e mode, em, pm;
    int num_errors, samples_checked, cyc, last, c, g, np, dly, w;
    int gtab[3] = '{400, 401, 450};
    int stab[10] = '{1500, 1300, 1176, 1000, 900, 1177, 2000, 1300, 3500, 2999};
    light_load_burst_mode_sequencer #(
        .STANDBY_LOWER_PERIOD(LOWER)
    ) u_dut (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_aux_zero_cross(zc),
        .i_demand(dem),
        .i_peak_trip(trip),
        .i_peak_at_floor(flr),
        .i_program_above(prg),
        .i_set_tied_ref(tie),
        .i_adaptive_start(ast),
        .i_adaptive_pulses(apul),
        .i_loop_code(loop_c),
        .i_program_code(prog_c),
        .i_on_time_code(on_c),
        .o_low_side_gate(gate),
        .o_high_side_gate(hs),
        .o_driver_wake(wake),
        .o_mode(mode),
        .o_pulses_per_packet(ppp),
        .o_peak_current_threshold(thr),
        .o_voltage_mode(vm)
    );
    burst_power_stage_model u_stage (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_gate(gate),
        .i_wake(wake),
        .i_slow(slow),
        .o_zero_cross(zc),
        .o_peak_trip(trip)
    );
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            test_done();
        end
    end
    // ----------------------------------------------------------------
    // expectations and helpers
    // ----------------------------------------------------------------
    function automatic int adapt_cnt(int n, logic [3:0] p, int per);
        return (p == 4'h2 && per > `BURST_LOW_PERIOD_CYC) ? n + 1 : 0;
    endfunction
    function automatic mode_e sb_next(mode_e m, int per, logic hi);
        if (m == MODE_STANDBY1 && per > `STANDBY_UPPER_PERIOD_CYC) return MODE_STANDBY2;
        if (m == MODE_STANDBY2 && per < (hi ? LOWER : `STANDBY_UPPER_PERIOD_CYC))
            return MODE_STANDBY1;
        return m;
    endfunction
    function automatic logic [7:0] clamp(logic [7:0] v);
        return (v < PMIN) ? PMIN : ((v > PMAX) ? PMAX : v);
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic adapt(int gap);
        while (cyc - last < gap) @(negedge i_clk);
        ast = 1'b1;
        last = cyc;
        @(negedge i_clk);
        ast = 1'b0;
    endtask
    // counts low-side pulses, wake-to-gate lead and last pulse width
    task automatic packet();
        logic gp;
        int t;
        gp = 1'b0;
        np = 0;
        dly = 0;
        w = 0;
        t = 0;
        while (wake !== 1'b1 && t < 2000) begin
            @(negedge i_clk);
            t++;
        end
        while (wake === 1'b1 && t < 4000) begin
            @(negedge i_clk);
            t++;
            if (gate === 1'b1) w = gp ? w + 1 : 1;
            if (gate === 1'b1 && !gp) np++;
            if (np == 0) dly++;
            gp = (gate === 1'b1);
        end
    endtask
    task automatic sb(int gap);
        while (cyc - last < gap) @(negedge i_clk);
        dem = 1'b1;
        last = cyc;
        slow = 1'($urandom % 2);
        while (wake !== 1'b1 && cyc - last < 100) @(negedge i_clk);
        dem = 1'b0;
        packet();
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(13929));
        {i_resetn, dem, flr, prg, tie, ast, slow} = 7'h00;
        apul = 4'h3;
        loop_c = 8'h80;
        prog_c = 8'h00;
        on_c = 8'h08;
        repeat (6) @(negedge i_clk);
        check("reset wake", wake, 1'b0);
        i_resetn = 1'b1;
        adapt(10);
        c = 0;
        for (int i = 0; i < 6 && c < 2; i++) begin
            g = (i < 3) ? gtab[i] : 401 + int'($urandom % 300);
            apul = (i == 2) ? 4'h3 : 4'h2;
            adapt(g);
            c = adapt_cnt(c, apul, g);
            repeat (3) @(negedge i_clk);
            check("mode", mode, (c >= 2) ? MODE_LOW_POWER : MODE_ADAPTIVE);
        end
        $display("test adaptive entry done");
        for (int k = 0; k < 3; k++) begin
            packet();
            loop_c = 8'h20 + 8'($urandom % 224);
            on_c = 8'h01 + 8'($urandom % 40);
            tie = (k == 2);
            slow = 1'($urandom % 2);
            packet();
            check("lp pulses", np, 2);
            check("wake lead", dly >= `WAKE_DELAY_CYC, 1);
            check("lp threshold", thr, loop_c);
            check("voltage mode", vm, tie);
            check("high side", hs, 1'b0);
            if (tie) check("on time", w >= on_c && w <= on_c + 3, 1);
        end
        $display("test low power done");
        tie = 1'b0;
        flr = 1'b1;
        repeat (20) @(negedge i_clk);
        check("floor mode", mode, MODE_STANDBY1);
        while (wake === 1'b1) @(negedge i_clk);
        c = 0;
        repeat (2000) begin
            @(negedge i_clk);
            c += (wake === 1'b1);
        end
        check("sb1 no demand", c, 0);
        check("sb1 threshold", thr, 8'h10);
        em = MODE_STANDBY1;
        for (int i = 0; i < 10; i++) begin
            prg = (i >= 5);
            prog_c = 8'($urandom);
            g = stab[i] + ((i == 1 || i == 8) ? int'($urandom % 400) : 0);
            pm = em;
            em = sb_next(em, g, prg);
            sb(g);
            check("sb mode", mode, em);
            if (pm == em) check("sb pulses", np, (em == MODE_STANDBY2) ? 4 : 2);
            if (em == MODE_STANDBY2) check("sb2 thr", thr, prg ? clamp(prog_c) : PMIN);
        end
        $display("test standby done");
        dem = 1'b1;
        repeat (30) @(negedge i_clk);
        i_resetn = 1'b0;
        dem = 1'b0;
        repeat (2) @(negedge i_clk);
        check("rst wake", wake, 1'b0);
        check("rst gate", gate, 1'b0);
        check("rst mode", mode, MODE_ADAPTIVE);
        check("rst pulses", ppp, 4'h2);
        i_resetn = 1'b1;
        repeat (5) @(negedge i_clk);
        check("idle mode", mode, MODE_ADAPTIVE);
        $display("test reset done");
        test_done();
    end
endmodule // tb_light_load_burst_mode_sequencer
`default_nettype wire
